// [design/pwm_steer_top.sv]
// PWM output stage: active-edge delay, auto restart and four-pin steering
`timescale 1ns/1ps
module pwm_steer_top #(
  parameter int DELAY_W = 7
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       pwm_raw_in,
  input  wire logic       period_start_in,
  input  wire logic       fault_in,
  input  wire logic [3:0] port_data_in,
  output logic      [3:0] pin_out,
  output logic      [3:0] pwm_active_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]         delay_ctrl_r;
  logic [4:0]         steer_ctrl_r;
  logic [7:0]         ccp_ctrl_r;
  logic [4:0]         steer_live_r;
  logic               steer_pend_r;
  logic               shutdown_r;
  logic [1:0]         phase_r;
  logic               tick;
  logic               pwm_dly;
  logic               steer_ok;
  logic               pwm_pol;
  logic               sw_clr_sd;

  // Count field width is fixed by the register layout
  if (DELAY_W != 7)
  begin : g_width_chk
    $error("DELAY_W must match the seven-bit count field");
  end

  assign tick      = (phase_r == 2'(pwm_steer_pkg::CLK_PER_INSTR - 1));
  assign sw_clr_sd = wr_in && addr_in == pwm_steer_pkg::ADDR_STATUS && !wdata_in[0];
  assign steer_ok  = ccp_ctrl_r[pwm_steer_pkg::MODE_LSB +: 2] == pwm_steer_pkg::MODE_PWM
                  && ccp_ctrl_r[pwm_steer_pkg::CFG_LSB +: 2] == pwm_steer_pkg::CFG_SINGLE;
  // Polarity bit (bit 0) set means active-low on these pins
  assign pwm_pol   = (pwm_dly & ~shutdown_r) ^ ccp_ctrl_r[pwm_steer_pkg::POL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle phase counter
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase_r <= 2'h0;
    else if (ce_in)
      phase_r <= phase_r + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      delay_ctrl_r <= pwm_steer_pkg::DELAY_CTRL_RST;
      steer_ctrl_r <= pwm_steer_pkg::STEER_CTRL_RST[4:0];
      ccp_ctrl_r   <= pwm_steer_pkg::CCP_CTRL_RST;
    end
    else if (ce_in && wr_in)
    begin
      unique case (addr_in)
        pwm_steer_pkg::ADDR_DELAY_CTRL: delay_ctrl_r <= wdata_in;
        pwm_steer_pkg::ADDR_STEER_CTRL: steer_ctrl_r <= wdata_in[4:0];
        pwm_steer_pkg::ADDR_CCP_CTRL:   ccp_ctrl_r   <= wdata_in;
        default:                        ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steering update timing; a write arms the pending flag
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      steer_live_r <= pwm_steer_pkg::STEER_CTRL_RST[4:0];
      steer_pend_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_in && addr_in == pwm_steer_pkg::ADDR_STEER_CTRL)
        steer_pend_r <= 1'b1;
      else if (steer_pend_r)
      begin
        if (steer_ctrl_r[pwm_steer_pkg::SYNC_BIT] ? period_start_in : tick)
        begin
          steer_live_r <= steer_ctrl_r;
          steer_pend_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown status: fault sets, restart or software clears; set wins
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      shutdown_r <= 1'b0;
    else if (ce_in)
    begin
      if (fault_in)
        shutdown_r <= 1'b1;
      else if (delay_ctrl_r[pwm_steer_pkg::RESTART_BIT] && period_start_in)
        shutdown_r <= 1'b0;
      else if (sw_clr_sd)
        shutdown_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pwm_edge_delay #(
    .CNT_W    (DELAY_W)
  ) u_delay (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .tick_in  (tick),
    .delay_in (delay_ctrl_r[DELAY_W-1:0]),
    .pwm_in   (pwm_raw_in),
    .pwm_out  (pwm_dly)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin output mux
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        pin_out[i]        <= 1'b0;
        pwm_active_out[i] <= 1'b0;
      end
      else if (ce_in)
      begin
        if (steer_ok && steer_live_r[pwm_steer_pkg::STEER_LSB + i])
        begin
          pin_out[i]        <= pwm_pol;
          pwm_active_out[i] <= 1'b1;
        end
        else
        begin
          pin_out[i]        <= port_data_in[i];
          pwm_active_out[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else if (ce_in)
    begin
      if (rd_in)
      begin
        unique case (addr_in)
          pwm_steer_pkg::ADDR_DELAY_CTRL: rdata_out <= delay_ctrl_r;
          pwm_steer_pkg::ADDR_STEER_CTRL: rdata_out <= {3'h0, steer_ctrl_r};
          pwm_steer_pkg::ADDR_CCP_CTRL:   rdata_out <= ccp_ctrl_r;
          default:                        rdata_out <= {7'h00, shutdown_r};
        endcase
      end
      else
        rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_steer_write_sync;
    wr_in && ce_in && addr_in == pwm_steer_pkg::ADDR_STEER_CTRL && wdata_in[pwm_steer_pkg::SYNC_BIT];
  endsequence

  AST_SYNC_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_steer_write_sync ##1 (!period_start_in && !wr_in && ce_in) |=> $stable(steer_live_r))
    else $error("steering changed before period start");
  AST_ASYNC_APPLY: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    steer_pend_r && !steer_ctrl_r[pwm_steer_pkg::SYNC_BIT] && tick && ce_in && !wr_in
      |=> steer_live_r == $past(steer_ctrl_r))
    else $error("steering not applied at instruction boundary");
  AST_DISABLED_PORT: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && !steer_live_r[0] |=> pin_out[0] == $past(port_data_in[0]))
    else $error("disabled pin did not follow port data");
  AST_MODE_GATE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && !steer_ok |=> pwm_active_out == 4'h0)
    else $error("steering active outside PWM single mode");
  AST_RESERVED_READ: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rd_in && ce_in && addr_in == pwm_steer_pkg::ADDR_STEER_CTRL |=> rdata_out[7:5] == 3'h0)
    else $error("reserved steering bits read nonzero");
  AST_POLARITY: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_in && steer_ok && steer_live_r[1] |=> pin_out[1] == $past(pwm_pol))
    else $error("steered pin has wrong waveform");
  AST_PIN_INDEP: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ce_in |=> pwm_active_out[3] == $past(steer_ok && steer_live_r[3]))
    else $error("pin D enable not independent");
  AST_NO_AUTO_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    shutdown_r && !delay_ctrl_r[pwm_steer_pkg::RESTART_BIT] && !sw_clr_sd |=> shutdown_r)
    else $error("shutdown status cleared without software");
  AST_DELAY_EDGE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(pwm_dly) |-> $past(pwm_raw_in) && $past(tick)
      && $past(u_delay.cnt_r) >= $past(delay_ctrl_r[DELAY_W-1:0]))
    else $error("PWM edge rose before delay count");
endmodule

// [design/pwm_steer_pkg.sv]
// Constants for the PWM delay, restart and steering output stage
package pwm_steer_pkg;
  localparam logic [1:0] ADDR_DELAY_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_STEER_CTRL  = 2'h1;
  localparam logic [1:0] ADDR_CCP_CTRL    = 2'h2;
  localparam logic [1:0] ADDR_STATUS      = 2'h3;
  localparam int         RESTART_BIT      = 7;
  localparam int         SYNC_BIT         = 4;
  localparam int         STEER_LSB        = 0;
  localparam int         STEER_MSB        = 3;
  localparam int         POL_LSB          = 0;
  localparam int         MODE_LSB         = 2;
  localparam int         CFG_LSB          = 6;
  localparam logic [7:0] DELAY_CTRL_RST   = 8'h00;
  localparam logic [7:0] STEER_CTRL_RST   = 8'h01;
  localparam logic [7:0] CCP_CTRL_RST     = 8'h00;
  localparam logic [7:0] STEER_WR_MASK    = 8'h1f;
  localparam logic [1:0] MODE_PWM         = 2'h3;
  localparam logic [1:0] CFG_SINGLE       = 2'h0;
  localparam int         CLK_PER_INSTR    = 4;
endpackage

// [design/pwm_edge_delay.sv]
// Delays the rising edge of a PWM level by a programmable count of ticks
`timescale 1ns/1ps
module pwm_edge_delay #(
  parameter int CNT_W = 7
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             tick_in,
  input  wire logic [CNT_W-1:0] delay_in,
  input  wire logic             pwm_in,
  output logic                  pwm_out
);
  logic [CNT_W-1:0] cnt_r;

  // Refused at elaboration, not at run time
  if (CNT_W < 1)
  begin : g_width_chk
    $error("CNT_W must be at least 1");
  end

  // Rising edges wait, falling edges pass at once
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r   <= '0;
      pwm_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!pwm_in)
      begin
        pwm_out <= 1'b0;
        cnt_r   <= '0;
      end
      else if (!pwm_out && tick_in)
      begin
        if (cnt_r >= delay_in)
          pwm_out <= 1'b1;
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// [tb/pin_load_model.sv]
// Load on the four steered pins: counts rising edges seen on pin A
`timescale 1ns/1ps
module pin_load_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] pin_in,
  output logic      [7:0] rise_cnt_out
);
  logic [3:0] last_r;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      last_r       <= 4'h0;
      rise_cnt_out <= 8'h00;
    end
    else
    begin
      last_r <= pin_in;
      if (pin_in[0] && !last_r[0])
        rise_cnt_out <= rise_cnt_out + 8'h01;
    end
  end
endmodule

// [tb/tb_pwm_steer_top.sv]
// Self-checking bench for the PWM delay, restart and steering stage
`timescale 1ns/1ps
module tb_pwm_steer_top;
  logic       mclk_in, rst_n_in, ce_in, wr_in, rd_in, pwm_raw_in, period_start_in, fault_in, inv;
  logic [1:0] addr_in;
  logic [7:0] wdata_in, rdata_out, rises, v;
  logic [3:0] port_data_in, pin_out, pwm_active_out, m;
  int         n_fail, checked, seed, n, d, i;
  logic [7:0] bad_cfg [6] = '{8'h00, 8'h04, 8'h08, 8'h4c, 8'h8c, 8'hcc};
  int         dly [4] = '{0, 1, 9, 127};

  pwm_steer_top i_pwm_steer_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwm_raw_in(pwm_raw_in),
    .period_start_in(period_start_in), .fault_in(fault_in), .port_data_in(port_data_in), .pin_out(pin_out),
    .pwm_active_out(pwm_active_out));
  pin_load_model i_pin_load_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(pin_out), .rise_cnt_out(rises));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] dt);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= dt;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task automatic pulse;
    @(posedge mclk_in);
    period_start_in <= 1'b1;
    @(posedge mclk_in);
    period_start_in <= 1'b0;
  endtask
  function automatic logic [3:0] exp_pins(input logic [3:0] en, input logic pol, input logic lvl,
                                          input logic [3:0] port);
    for (int k = 0; k < 4; k++)
      exp_pins[k] = en[k] ? (lvl ^ pol) : port[k];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Whole sequence needs well under 10k cycles
  initial
  begin
    #200000;
    n_fail++;
    final_report;
  end

  initial
  begin
    {rst_n_in, wr_in, rd_in, pwm_raw_in, period_start_in, fault_in} = 6'h00;
    ce_in = 1'b1;
    addr_in = 2'h0;
    wdata_in = 8'h00;
    port_data_in = 4'h0;
    seed = 73;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(2'h0);
    chk(v, 8'h00);
    rd(2'h1);
    chk(v, 8'h01);
    wr(2'h1, 8'hff);
    rd(2'h1);
    chk(v, 8'h1f);
    foreach (bad_cfg[j])
    begin
      wr(2'h2, bad_cfg[j]);
      @(posedge mclk_in);
      port_data_in <= 4'($random(seed));
      pwm_raw_in   <= 1'b1;
      cyc(10);
      chk({pwm_active_out, pin_out}, {4'h0, port_data_in});
    end
    for (i = 0; i < 16; i++)
    begin
      v = 8'($random(seed));
      inv = v[0];
      m = 4'(i);
      wr(2'h2, 8'h0c | {7'h00, inv});
      wr(2'h1, {4'h0, m});
      @(posedge mclk_in);
      port_data_in <= 4'($random(seed));
      pwm_raw_in   <= v[1];
      cyc(12);
      chk({pwm_active_out, pin_out}, {m, exp_pins(m, inv, v[1], port_data_in)});
    end
    wr(2'h2, 8'h0c);
    wr(2'h1, 8'h01);
    foreach (dly[j])
    begin
      d = dly[j];
      wr(2'h0, 8'(d));
      @(posedge mclk_in);
      pwm_raw_in <= 1'b0;
      cyc(8);
      v = rises;
      @(posedge mclk_in);
      pwm_raw_in <= 1'b1;
      n = 0;
      #1;
      while (pin_out[0] !== 1'b1 && n < 600)
      begin
        cyc(1);
        n++;
      end
      chk({7'h00, n >= 4 * d + 1 && n <= 4 * d + 7}, 8'h01);
      // Load model registers the rise one edge after the pin
      cyc(1);
      chk(rises - v, 8'h01);
      @(posedge mclk_in);
      pwm_raw_in <= 1'b0;
      cyc(2);
      chk({7'h00, pin_out[0]}, 8'h00);
    end
    wr(2'h1, 8'h1f);
    pulse;
    cyc(4);
    chk({4'h0, pwm_active_out}, 8'h0f);
    wr(2'h1, 8'h12);
    cyc(20);
    chk({4'h0, pwm_active_out}, 8'h0f);
    pulse;
    cyc(2);
    chk({4'h0, pwm_active_out}, 8'h02);
    wr(2'h1, 8'h05);
    n = 0;
    #1;
    while (pwm_active_out !== 4'h5 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, n <= 6}, 8'h01);
    // Restart off: status sticks until software clears it
    wr(2'h0, 8'h00);
    @(posedge mclk_in);
    fault_in   <= 1'b1;
    pwm_raw_in <= 1'b1;
    cyc(12);
    chk({7'h00, pin_out[0]}, 8'h00);
    rd(2'h3);
    chk(v, 8'h01);
    @(posedge mclk_in);
    fault_in <= 1'b0;
    pulse;
    cyc(3);
    rd(2'h3);
    chk(v, 8'h01);
    wr(2'h3, 8'h00);
    rd(2'h3);
    chk(v, 8'h00);
    wr(2'h0, 8'h80);
    @(posedge mclk_in);
    fault_in <= 1'b1;
    cyc(3);
    @(posedge mclk_in);
    fault_in <= 1'b0;
    pulse;
    cyc(12);
    rd(2'h3);
    chk(v, 8'h00);
    chk({7'h00, pin_out[0]}, 8'h01);
    // Clock enable low: writes dropped, pins frozen
    @(posedge mclk_in);
    ce_in <= 1'b0;
    #1 m = pin_out;
    @(posedge mclk_in);
    port_data_in <= ~port_data_in;
    wr(2'h0, 8'h05);
    cyc(3);
    chk({4'h0, pin_out}, {4'h0, m});
    @(posedge mclk_in);
    ce_in <= 1'b1;
    rd(2'h0);
    chk(v, 8'h80);
    final_report;
  end
endmodule
